// ### hw/ivtm_defs.svh
// Constants of the interrupt vector and trap map: offsets, fields, trap numbers.
`ifndef IVTM_DEFS_SVH
`define IVTM_DEFS_SVH
// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define IVTM_NSRC 56
`define IVTM_NTRAP 8
`define IVTM_VEC_W 24
// ----------------------------------------------------------------------------
// Register byte offsets (APB, one aligned word each)
// ----------------------------------------------------------------------------
`define IVTM_OFS_CTRL0 12'h000
`define IVTM_OFS_CTRL_END 12'h0e0
`define IVTM_OFS_TRAP_FLAG 12'h100
`define IVTM_OFS_EVT_STAT 12'h104
`define IVTM_OFS_EVT_MASK 12'h108
`define IVTM_OFS_PEC_LO 12'h10c
`define IVTM_OFS_PEC_HI 12'h110
`define IVTM_OFS_SERV 12'h114
// ----------------------------------------------------------------------------
// Source control word fields and reset value
// ----------------------------------------------------------------------------
`define IVTM_CTL_REQ 7
`define IVTM_CTL_EN 6
`define IVTM_CTL_LVL_HI 5
`define IVTM_CTL_LVL_LO 2
`define IVTM_CTL_GRP_HI 1
`define IVTM_CTL_RST 8'h00
// ----------------------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------------------
`define IVTM_EVT_TRAP 0
`define IVTM_EVT_INT 1
`define IVTM_EVT_PEC 2
`define IVTM_EVT_W 3
// ----------------------------------------------------------------------------
// Trap numbers of the source groups
// ----------------------------------------------------------------------------
`define IVTM_TN_CC0 7'h10
`define IVTM_TN_CC16 7'h30
`define IVTM_TN_CC29 7'h44
`define IVTM_TN_T0 7'h20
`define IVTM_TN_T1 7'h21
`define IVTM_TN_T7 7'h3d
`define IVTM_TN_T8 7'h3e
`define IVTM_TN_T2 7'h22
`define IVTM_TN_ADC 7'h28
`define IVTM_TN_ADE 7'h29
`define IVTM_TN_S0T 7'h2a
`define IVTM_TN_S0TB 7'h47
`define IVTM_TN_S0R 7'h2b
`define IVTM_TN_S0E 7'h2c
`define IVTM_TN_SCT 7'h2d
`define IVTM_TN_PWM 7'h3f
`define IVTM_TN_XP0 7'h40
// Hardware trap numbers: three class A, one shared class B
`define IVTM_TN_NMI 7'h02
`define IVTM_TN_CLSB 7'h0a
`define IVTM_NCLSA 3
`endif

// ### hw/ivtm_pkg.sv
// Types and the source-to-trap-number map of the interrupt vector and trap map.
`include "ivtm_defs.svh"
package ivtm_pkg;
  // Offer states towards the core
  typedef enum logic [0:0] {ST_IDLE, ST_OFFER} ivtm_state_t;
  // What kind of service is offered
  typedef enum logic [1:0] {K_INT, K_PEC, K_TRAP} ivtm_kind_t;

  // Trap number of a request source, by source index
  function automatic logic [6:0] ivtm_src_num(input logic [5:0] i);
    logic [6:0] n;
    n = {1'b0, i};
    if (i < 6'd16) return `IVTM_TN_CC0 + n;
    if (i < 6'd29) return `IVTM_TN_CC16 + n - 7'd16;
    if (i < 6'd32) return `IVTM_TN_CC29 + n - 7'd29;
    case (i)
      6'd32: return `IVTM_TN_T0;
      6'd33: return `IVTM_TN_T1;
      6'd34: return `IVTM_TN_T7;
      6'd35: return `IVTM_TN_T8;
      6'd42: return `IVTM_TN_ADC;
      6'd43: return `IVTM_TN_ADE;
      6'd44: return `IVTM_TN_S0T;
      6'd45: return `IVTM_TN_S0TB;
      6'd46: return `IVTM_TN_S0R;
      6'd47: return `IVTM_TN_S0E;
      6'd51: return `IVTM_TN_PWM;
      default: begin
        if (i < 6'd42) return `IVTM_TN_T2 + n - 7'd36;
        if (i < 6'd51) return `IVTM_TN_SCT + n - 7'd48;
        return `IVTM_TN_XP0 + n - 7'd52;
      end
    endcase
  endfunction : ivtm_src_num

  // Vector byte address is four times the trap number
  function automatic logic [`IVTM_VEC_W-1:0] ivtm_vec(input logic [6:0] n);
    return {{(`IVTM_VEC_W-9){1'b0}}, n, 2'b00};
  endfunction : ivtm_vec
endpackage : ivtm_pkg

// ### hw/ivtm_arb.sv
// Priority arbiter over all enabled, pending request sources.
`timescale 1ns/1ps
`include "ivtm_defs.svh"
module ivtm_arb (
  input wire logic [7:0] ctrl_i [`IVTM_NSRC],
  output logic win_valid_o,
  output logic [5:0] win_idx_o,
  output logic [3:0] win_lvl_o
);
  // --------------------------------------------------------------------------
  // Search for the highest level/group key
  // --------------------------------------------------------------------------
  logic [5:0] best_key; // Level above group, compared as one number
  // Strict compare keeps the lowest index on a full tie
  always_comb begin
    win_valid_o = 1'b0;
    win_idx_o = 6'h00;
    best_key = 6'h00;
    for (int i = 0; i < `IVTM_NSRC; i++) begin
      if (ctrl_i[i][`IVTM_CTL_REQ] && ctrl_i[i][`IVTM_CTL_EN]) begin // [R11]
        if (!win_valid_o || ctrl_i[i][5:0] > best_key) begin // [R12] [R13]
          win_valid_o = 1'b1;
          win_idx_o = i[5:0];
          best_key = ctrl_i[i][5:0];
        end
      end
    end
    win_lvl_o = best_key[5:2];
  end
endmodule : ivtm_arb

// ### hw/ivtm_top.sv
// Interrupt vector and trap map: source flags, arbitration, traps, APB slave.
//
// Behaviour
// [R01] Every source: request, enable, vector equals 4*number
// [R02] Capture channels map to 10h, 30h, 44h ranges
// [R03] Each request serviced as interrupt or transfer
// [R04] Capture timers and general timers map 20h-27h, 3Dh-3Eh
// [R05] Converter and serial channels map 28h-2Fh, 47h
// [R06] Pulse unit, bus controllers, flash, clock fault map
// [R07] Hardware traps non-maskable, branch to own vector; here only the class A traps have their own, all class B traps share number 0Ah
// [R08] Each trap sets its own trap flag bit
// [R09] Trap preempts all but higher trap service
// [R10] Trap service blocks interrupts and transfers
// [R11] Only enabled requests take part in arbitration
// [R12] Four-bit priority level, Fh highest
// [R13] Two-bit group level breaks equal-level ties
`timescale 1ns/1ps
`include "ivtm_defs.svh"
module ivtm_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral request pulses and hardware trap pulses
  input wire logic [`IVTM_NSRC-1:0] src_evt_i,
  input wire logic [`IVTM_NTRAP-1:0] hw_trap_i,
  // Core side
  input wire logic [3:0] cpu_lvl_i,
  input wire logic ack_i,
  input wire logic trap_done_i,
  output logic req_o,
  output logic [1:0] kind_o,
  output logic [6:0] trap_num_o,
  output logic [`IVTM_VEC_W-1:0] vec_addr_o,
  output logic [5:0] src_idx_o,
  output logic irq_o
);
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0] ctrl_r [`IVTM_NSRC]; // Per-source control words
  logic [7:0] ctrl_nxt [`IVTM_NSRC];
  logic [`IVTM_NTRAP-1:0] tfr_r, tfr_nxt; // Trap flag register, software view
  logic [`IVTM_NTRAP-1:0] tpend_r, tpend_nxt; // Traps waiting for the core
  logic [`IVTM_NSRC-1:0] pecsel_r, pecsel_nxt; // One: serviced as transfer
  logic [`IVTM_EVT_W-1:0] stat_r, stat_nxt; // Sticky service events
  logic [`IVTM_EVT_W-1:0] mask_r, mask_nxt; // Event interrupt mask
  ivtm_pkg::ivtm_state_t st_r, st_nxt; // Offer state
  logic req_r, req_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [6:0] num_r, num_nxt;
  logic [`IVTM_VEC_W-1:0] vec_r, vec_nxt;
  logic [5:0] src_r, src_nxt;
  logic [2:0] tidx_r, tidx_nxt; // Trap bit index being offered
  logic trun_r, trun_nxt; // A trap service is running
  logic [1:0] tprio_r, tprio_nxt; // Priority of the running trap
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic irq_r, irq_nxt;

  // --------------------------------------------------------------------------
  // Arbitration between sources
  // --------------------------------------------------------------------------
  logic win_valid;
  logic [5:0] win_idx;
  logic [3:0] win_lvl;

  ivtm_arb u_arb (
    .ctrl_i(ctrl_r),
    .win_valid_o(win_valid),
    .win_idx_o(win_idx),
    .win_lvl_o(win_lvl)
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Class A traps outrank class B; lower bit wins inside the pending set
  function automatic logic [1:0] trap_prio(input logic [2:0] t);
    return (t < 3'(`IVTM_NCLSA)) ? 2'd2 : 2'd1;
  endfunction : trap_prio

  // Class A traps own their number, class B share one
  function automatic logic [6:0] trap_num(input logic [2:0] t);
    return (t < 3'(`IVTM_NCLSA)) ? `IVTM_TN_NMI + {3'b000, t, 1'b0} : `IVTM_TN_CLSB;
  endfunction : trap_num

  logic tp_any; // Some trap is waiting
  logic [2:0] tp_idx; // Highest waiting trap
  // Pick the highest waiting trap
  always_comb begin
    tp_any = 1'b0;
    tp_idx = 3'd0;
    for (int t = `IVTM_NTRAP - 1; t >= 0; t--) begin
      if (tpend_r[t]) begin
        tp_any = 1'b1;
        tp_idx = t[2:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic acc; // Access phase, answer in this cycle
  logic is_ctrl; // Address hits a source control word
  logic [5:0] aidx; // Source index of that word
  logic hit; // Address is mapped
  logic wr; // Write takes effect at this edge
  always_comb begin
    acc = psel_i & penable_i & pready_r;
    is_ctrl = (paddr_i < `IVTM_OFS_CTRL_END) && (paddr_i[1:0] == 2'b00);
    aidx = paddr_i[7:2];
    hit = is_ctrl || paddr_i == `IVTM_OFS_TRAP_FLAG || paddr_i == `IVTM_OFS_EVT_STAT ||
          paddr_i == `IVTM_OFS_EVT_MASK || paddr_i == `IVTM_OFS_PEC_LO ||
          paddr_i == `IVTM_OFS_PEC_HI || paddr_i == `IVTM_OFS_SERV;
    wr = acc & pwrite_i & hit;
  end

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Order inside: software write, then hardware clear, then hardware set,
  // so a hardware event in the clearing cycle is never lost.
  always_comb begin
    ctrl_nxt = ctrl_r;
    tfr_nxt = tfr_r;
    tpend_nxt = tpend_r;
    pecsel_nxt = pecsel_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    st_nxt = st_r;
    req_nxt = req_r;
    kind_nxt = kind_r;
    num_nxt = num_r;
    vec_nxt = vec_r;
    src_nxt = src_r;
    tidx_nxt = tidx_r;
    trun_nxt = trun_r;
    tprio_nxt = tprio_r;
    // Bus: one wait state, then answer
    pready_nxt = psel_i & penable_i & ~pready_r;
    pslverr_nxt = pready_nxt & ~hit;
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt && hit) begin
      if (is_ctrl) begin
        prdata_nxt = {24'h000000, ctrl_r[aidx]};
      end else begin
        case (paddr_i)
          `IVTM_OFS_TRAP_FLAG: prdata_nxt = {24'h000000, tfr_r};
          `IVTM_OFS_EVT_STAT: prdata_nxt = {29'h0, stat_r};
          `IVTM_OFS_EVT_MASK: prdata_nxt = {29'h0, mask_r};
          `IVTM_OFS_PEC_LO: prdata_nxt = pecsel_r[31:0];
          `IVTM_OFS_PEC_HI: prdata_nxt = {8'h00, pecsel_r[`IVTM_NSRC-1:32]};
          `IVTM_OFS_SERV: prdata_nxt = {14'h0, src_r, 1'b0, num_r, trun_r, req_r, kind_r};
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    // Software writes
    if (wr) begin
      if (is_ctrl) begin
        ctrl_nxt[aidx] = pwdata_i[7:0]; // [R01]
      end else begin
        case (paddr_i)
          `IVTM_OFS_TRAP_FLAG: tfr_nxt = tfr_r & ~pwdata_i[`IVTM_NTRAP-1:0];
          `IVTM_OFS_EVT_STAT: stat_nxt = stat_r & ~pwdata_i[`IVTM_EVT_W-1:0];
          `IVTM_OFS_EVT_MASK: mask_nxt = pwdata_i[`IVTM_EVT_W-1:0];
          `IVTM_OFS_PEC_LO: pecsel_nxt[31:0] = pwdata_i; // [R03]
          `IVTM_OFS_PEC_HI: pecsel_nxt[`IVTM_NSRC-1:32] = pwdata_i[23:0];
          default: ;
        endcase
      end
    end
    // Running trap ends when the core says so
    if (trap_done_i) begin
      trun_nxt = 1'b0;
    end
    // Offer towards the core
    case (st_r)
      ivtm_pkg::ST_IDLE: begin
        // Trap wins unless a higher trap is running
        if (tp_any && (!trun_r || trap_prio(tp_idx) >= tprio_r)) begin // [R07] [R09]
          st_nxt = ivtm_pkg::ST_OFFER;
          req_nxt = 1'b1;
          kind_nxt = ivtm_pkg::K_TRAP;
          tidx_nxt = tp_idx;
          num_nxt = trap_num(tp_idx);
          vec_nxt = ivtm_pkg::ivtm_vec(trap_num(tp_idx)); // [R07]
          src_nxt = 6'h00;
        end else if (!tp_any && !trun_r && win_valid && win_lvl > cpu_lvl_i) begin // [R10] [R12]
          st_nxt = ivtm_pkg::ST_OFFER;
          req_nxt = 1'b1;
          kind_nxt = pecsel_r[win_idx] ? ivtm_pkg::K_PEC : ivtm_pkg::K_INT; // [R03]
          num_nxt = ivtm_pkg::ivtm_src_num(win_idx); // [R02] [R04] [R05] [R06]
          vec_nxt = ivtm_pkg::ivtm_vec(ivtm_pkg::ivtm_src_num(win_idx)); // [R01]
          src_nxt = win_idx;
        end
      end
      ivtm_pkg::ST_OFFER: begin
        if (ack_i) begin
          st_nxt = ivtm_pkg::ST_IDLE;
          req_nxt = 1'b0;
          if (kind_r == ivtm_pkg::K_TRAP) begin
            tpend_nxt[tidx_r] = 1'b0;
            trun_nxt = 1'b1;
            tprio_nxt = trap_prio(tidx_r);
            stat_nxt[`IVTM_EVT_TRAP] = 1'b1;
          end else begin
            // Taken service consumes the request flag on both paths
            ctrl_nxt[src_r][`IVTM_CTL_REQ] = 1'b0; // [R03]
            if (kind_r == ivtm_pkg::K_PEC) begin
              stat_nxt[`IVTM_EVT_PEC] = 1'b1;
            end else begin
              stat_nxt[`IVTM_EVT_INT] = 1'b1;
            end
          end
        end else if (kind_r != ivtm_pkg::K_TRAP && (tp_any || trun_r)) begin
          // A trap arrived: withdraw the ordinary offer at once
          st_nxt = ivtm_pkg::ST_IDLE; // [R09] [R10]
          req_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = ivtm_pkg::ST_IDLE;
        req_nxt = 1'b0;
      end
    endcase
    // Hardware sets last, so they win over any clear in the same cycle
    for (int i = 0; i < `IVTM_NSRC; i++) begin
      if (src_evt_i[i]) begin
        ctrl_nxt[i][`IVTM_CTL_REQ] = 1'b1; // [R01]
      end
    end
    tfr_nxt = tfr_nxt | hw_trap_i; // [R08]
    tpend_nxt = tpend_nxt | hw_trap_i; // [R07]
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `IVTM_NSRC; i++) begin
        ctrl_r[i] <= `IVTM_CTL_RST;
      end
      tfr_r <= 8'h00;
      tpend_r <= 8'h00;
      pecsel_r <= 56'h00_0000_0000_0000;
      stat_r <= 3'h0;
      mask_r <= 3'h0;
      st_r <= ivtm_pkg::ST_IDLE;
      req_r <= 1'b0;
      kind_r <= 2'h0;
      num_r <= 7'h00;
      vec_r <= 24'h000000;
      src_r <= 6'h00;
      tidx_r <= 3'h0;
      trun_r <= 1'b0;
      tprio_r <= 2'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      tfr_r <= tfr_nxt;
      tpend_r <= tpend_nxt;
      pecsel_r <= pecsel_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      st_r <= st_nxt;
      req_r <= req_nxt;
      kind_r <= kind_nxt;
      num_r <= num_nxt;
      vec_r <= vec_nxt;
      src_r <= src_nxt;
      tidx_r <= tidx_nxt;
      trun_r <= trun_nxt;
      tprio_r <= tprio_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // --------------------------------------------------------------------------
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign req_o = req_r;
  assign kind_o = kind_r;
  assign trap_num_o = num_r;
  assign vec_addr_o = vec_r;
  assign src_idx_o = src_r;
  assign irq_o = irq_r;
endmodule : ivtm_top

// ### bench/ivtm_map_pkg.sv
// Expected trap number of every request source, kept apart from the design's map.
package ivtm_map_pkg;
  // Trap number by source index, worked out group by group
  function automatic logic [6:0] exp_num(input int i);
    logic [6:0] n;
    n = 7'(i);
    if (i < 16) return 7'h10 + n;
    if (i < 29) return 7'h20 + n;
    if (i < 32) return 7'h27 + n;
    if (i < 34) return n;
    if (i < 36) return 7'h1b + n;
    if (i < 42) return n - 7'h02;
    if (i < 44) return n - 7'h02;
    if (i == 44) return 7'h2a;
    if (i == 45) return 7'h47;
    if (i < 51) return n - 7'h03;
    if (i == 51) return 7'h3f;
    return n + 7'h0c;
  endfunction : exp_num
endpackage : ivtm_map_pkg

// ### bench/ivtm_core_model.sv
// Behavioural core that takes the offers of the interrupt vector and trap map.
`timescale 1ns/1ps
module ivtm_core_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [1:0] kind_i,
  input wire logic [6:0] num_i,
  input wire logic [23:0] vec_i,
  input wire logic ack_en_i,
  input wire logic done_en_i,
  input wire logic [3:0] ack_dly_i,
  output logic ack_o,
  output logic done_o,
  output logic [1:0] last_kind_o,
  output logic [6:0] last_num_o,
  output logic [23:0] last_vec_o,
  output logic [7:0] n_taken_o
);
  // ----
  // Offer handshake
  // ----
  logic [3:0] wait_r; // Cycles the offer has stood, saturating
  logic run_r; // Trap service in progress
  // Acks after a set delay, so a slow core shows whether offers stand
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {wait_r, run_r, ack_o, done_o, last_kind_o, last_num_o, last_vec_o, n_taken_o} <= '0;
    end else begin
      ack_o <= 1'b0;
      done_o <= 1'b0;
      if (req_i && ack_o) begin
        // Taken: log where the core branches
        {last_kind_o, last_num_o, last_vec_o} <= {kind_i, num_i, vec_i};
        n_taken_o <= n_taken_o + 8'h01;
        run_r <= (kind_i == 2'h2);
        wait_r <= 4'h0;
      end else if (req_i && ack_en_i && wait_r >= ack_dly_i) begin
        ack_o <= 1'b1;
      end else if (req_i && wait_r != 4'hf) begin
        wait_r <= wait_r + 4'h1;
      end else if (!req_i) begin
        wait_r <= 4'h0;
      end
      // Trap service ends only when the bench allows it
      if (run_r && done_en_i && !done_o) begin
        done_o <= 1'b1;
        run_r <= 1'b0;
      end
    end
  end
endmodule : ivtm_core_model

// ### bench/ivtm_top_properties.sv
// Checker of offers and trap handling at the ports of the vector and trap map.
`timescale 1ns/1ps
`include "ivtm_defs.svh"
module ivtm_top_properties (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic [`IVTM_NTRAP-1:0] hw_trap_i,
  input wire logic ack_i,
  input wire logic trap_done_i,
  input wire logic req_o,
  input wire logic [1:0] kind_o,
  input wire logic [6:0] trap_num_o,
  input wire logic [`IVTM_VEC_W-1:0] vec_addr_o,
  input wire logic [5:0] src_idx_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Trap service running, seen through the core handshake only
  logic run_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_r <= 1'b0;
    end else if (req_o && ack_i) begin
      run_r <= (kind_o == 2'h2);
    end else if (trap_done_i) begin
      run_r <= 1'b0;
    end
  end
  // ----
  // Properties
  // ----
  a_vec_equal: assert property (
    req_o |-> vec_addr_o == {15'h0, trap_num_o, 2'b00})
    else $error("vector address is not four times the trap number");
  a_src_num: assert property (
    req_o && kind_o != 2'h2 |-> trap_num_o == ivtm_map_pkg::exp_num(int'(src_idx_o)))
    else $error("source offered with a wrong trap number");
  a_trap_code: assert property (
    req_o && kind_o == 2'h2 |-> src_idx_o == 6'h0 && trap_num_o inside {7'h2, 7'h4, 7'h6, 7'ha})
    else $error("trap offered with a wrong number");
  a_trap_offer: assert property (
    hw_trap_i != 8'h0 && !req_o && !run_r |-> ##[1:5] (req_o && kind_o == 2'h2))
    else $error("hardware trap not offered in time");
  a_trap_preempt: assert property (
    req_o && kind_o != 2'h2 && !ack_i && hw_trap_i != 8'h0 |-> ##[1:5] (req_o && kind_o == 2'h2))
    else $error("trap did not preempt a standing offer");
  a_trap_block: assert property (
    run_r |-> !(req_o && kind_o != 2'h2))
    else $error("interrupt or transfer offered during trap service");
  a_ack_clear: assert property (
    req_o && ack_i |=> !req_o)
    else $error("offer still standing after it was taken");
  a_apb_wait: assert property (
    $rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
    else $error("bus answer not in the second access cycle");
endmodule : ivtm_top_properties
bind ivtm_top ivtm_top_properties chk_u (.mclk_i, .rst_n_i, .psel_i, .penable_i, .pready_o,
  .hw_trap_i, .ack_i, .trap_done_i, .req_o, .kind_o, .trap_num_o, .vec_addr_o, .src_idx_o);

// ### bench/ivtm_top_test.sv
// Self-checking bench of the interrupt vector and trap map.
`timescale 1ns/1ps
`include "ivtm_defs.svh"
module ivtm_top_test;
  logic mclk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
  logic ack_i, trap_done_i, req_o, err, ack_en, done_en;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [`IVTM_NSRC-1:0] src_evt_i;
  logic [`IVTM_NTRAP-1:0] hw_trap_i;
  logic [3:0] cpu_lvl_i, ack_dly;
  logic [1:0] kind_o, last_kind;
  logic [6:0] trap_num_o, last_num;
  logic [`IVTM_VEC_W-1:0] vec_addr_o, last_vec;
  logic [5:0] src_idx_o;
  logic [7:0] n_taken;
  int n_mismatch, compares, cyc;
  ivtm_top dut_u (.mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .src_evt_i, .hw_trap_i, .cpu_lvl_i, .ack_i, .trap_done_i,
    .req_o, .kind_o, .trap_num_o, .vec_addr_o, .src_idx_o, .irq_o);
  ivtm_core_model core_u (.mclk_i, .rst_n_i, .req_i(req_o), .kind_i(kind_o), .num_i(trap_num_o),
    .vec_i(vec_addr_o), .ack_en_i(ack_en), .done_en_i(done_en), .ack_dly_i(ack_dly),
    .ack_o(ack_i), .done_o(trap_done_i), .last_kind_o(last_kind), .last_num_o(last_num),
    .last_vec_o(last_vec), .n_taken_o(n_taken));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Hang guard: the run needs a few thousand cycles at most
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", nm, exp, got);
      n_mismatch++;
    end
  endtask : chk
  // One bus transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    {rd, err} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
    @(posedge mclk_i);
  endtask : apb
  task automatic evt(input int i);
    src_evt_i[i] <= 1'b1;
    @(posedge mclk_i);
    src_evt_i <= '0;
  endtask : evt
  task automatic trap(input int i);
    hw_trap_i[i] <= 1'b1;
    @(posedge mclk_i);
    hw_trap_i <= '0;
  endtask : trap
  // Wait for the core to take an offer, then judge what it took
  task automatic take(input logic [6:0] num, input logic [1:0] k);
    logic [7:0] c;
    int n;
    c = n_taken;
    n = 0;
    while (n_taken === c && n < 40) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 40) n_mismatch++;
    chk("num", 32'(num), 32'(last_num));
    chk("vec", {23'h0, num, 2'b00}, 32'(last_vec));
    chk("kind", 32'(k), 32'(last_kind));
  endtask : take
  task automatic offer(input logic [1:0] k);
    int n;
    n = 0;
    while (!(req_o === 1'b1 && kind_o === k) && n < 20) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 20) n_mismatch++;
    chk("offer kind", 32'(k), 32'(kind_o));
  endtask : offer
  task automatic quiet(input string nm);
    logic [7:0] c;
    c = n_taken;
    repeat (6) @(posedge mclk_i);
    chk(nm, 32'(c), 32'(n_taken));
  endtask : quiet
  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    chk("req rst", 32'h0, 32'(req_o));
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl rst", 32'h0, rd);
    cpu_lvl_i <= 4'hf;
    apb(1'b1, 12'h004, 32'hffff_ffff);
    apb(1'b0, 12'h004, 32'h0);
    chk("ctrl rw", 32'hff, rd);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h200, 32'h1);
    chk("slverr", 32'h1, 32'(err));
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped", 32'h0, rd);
    cpu_lvl_i <= 4'h0;
  endtask : t_regs
  // Every source, with a core that answers at once or slowly
  task automatic t_map();
    for (int i = 0; i < `IVTM_NSRC; i++) begin
      ack_dly <= 4'(i % 4);
      apb(1'b1, 12'(4 * i), 32'h44);
      evt(i);
      take(ivtm_map_pkg::exp_num(i), 2'h0);
    end
  endtask : t_map
  task automatic t_order();
    apb(1'b1, 12'h014, 32'h04);
    evt(5);
    quiet("disabled");
    apb(1'b0, 12'h014, 32'h0);
    chk("flag", 32'h84, rd);
    apb(1'b1, 12'h014, 32'hc4);
    take(7'h15, 2'h0);
    apb(1'b1, 12'h008, 32'h4c);
    apb(1'b1, 12'h01c, 32'h4e);
    apb(1'b1, 12'h024, 32'h4b);
    src_evt_i <= 56'h284;
    @(posedge mclk_i);
    src_evt_i <= '0;
    take(7'h17, 2'h0);
    take(7'h12, 2'h0);
    take(7'h19, 2'h0);
    cpu_lvl_i <= 4'h3;
    evt(7);
    quiet("level gate");
    cpu_lvl_i <= 4'h2;
    take(7'h17, 2'h0);
    cpu_lvl_i <= 4'h0;
  endtask : t_order
  task automatic t_irq();
    apb(1'b1, 12'h104, 32'h7);
    apb(1'b1, 12'h108, 32'h4);
    apb(1'b1, 12'h10c, 32'h10);
    evt(3);
    take(7'h13, 2'h0);
    repeat (2) @(posedge mclk_i);
    chk("irq masked", 32'h0, 32'(irq_o));
    evt(4);
    take(7'h14, 2'h1);
    repeat (2) @(posedge mclk_i);
    chk("irq", 32'h1, 32'(irq_o));
    apb(1'b0, 12'h104, 32'h0);
    chk("status", 32'h6, rd);
    apb(1'b1, 12'h104, 32'h4);
    @(posedge mclk_i);
    chk("irq clr", 32'h0, 32'(irq_o));
  endtask : t_irq
  task automatic t_trap();
    ack_en <= 1'b0;
    done_en <= 1'b0;
    evt(5);
    offer(2'h0);
    trap(0);
    offer(2'h2);
    chk("trap num", 32'h2, 32'(trap_num_o));
    ack_en <= 1'b1;
    take(7'h02, 2'h2);
    apb(1'b0, 12'h100, 32'h0);
    chk("trap flag", 32'h1, rd);
    apb(1'b0, 12'h114, 32'h0);
    chk("service", 32'h2a, rd);
    quiet("blocked");
    done_en <= 1'b1;
    take(7'h15, 2'h0);
    trap(3);
    take(7'h0a, 2'h2);
    trap(1);
    take(7'h04, 2'h2);
    apb(1'b0, 12'h100, 32'h0);
    chk("trap flags", 32'h0b, rd);
    apb(1'b1, 12'h100, 32'h0b);
    apb(1'b0, 12'h100, 32'h0);
    chk("trap clr", 32'h0, rd);
  endtask : t_trap
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {src_evt_i, hw_trap_i, cpu_lvl_i, ack_dly} = '0;
    {ack_en, done_en} = 2'b11;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_map();
    t_order();
    t_irq();
    t_trap();
    finish_test();
  end
endmodule : ivtm_top_test
